// File: common/acs_params.svh
// constants for the conversion sequencer: offsets, fields, resets, timing
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define ACS_ADDR_SETUP 8'h00
`define ACS_ADDR_CONFIG 8'h04
`define ACS_ADDR_DIAG 8'h08
`define ACS_ADDR_CAL 8'h0c
`define ACS_ADDR_RES_SHUNT 8'h10
`define ACS_ADDR_RES_BUS 8'h14
`define ACS_ADDR_RES_TEMP 8'h18
`define ACS_ADDR_RES_CUR 8'h1c
`define ACS_ADDR_RES_PWR 8'h20

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define ACS_SETUP_W 17
`define ACS_DLY_W 8
`define ACS_DIAG_DONE_BIT 0

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define ACS_SETUP_RST 17'h029be
`define ACS_DLY_RST 8'h00
`define ACS_CAL_RST 16'h0000

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define ACS_CLK_NS 10
`define ACS_US_CYC (1000 / `ACS_CLK_NS)
`define ACS_DLY_STEP_MS 2
`define ACS_DLY_STEP_CYC (`ACS_DLY_STEP_MS * 1000000 / `ACS_CLK_NS)
`define ACS_CT_MIN_US 50
`define ACS_CT_MAX_US 4120
`define ACS_CUR_SHIFT 11

`endif

// File: common/acs_pkg.sv
// types shared by the conversion sequencer modules
package acs_pkg;

    // -----------------------------------------------------------------
    // operating mode and sequencer states
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        ACS_OP_OFF = 2'h0,
        ACS_OP_TRIG = 2'h1,
        ACS_OP_CONT = 2'h2,
        ACS_OP_CONT2 = 2'h3
    } acs_op_e;

    typedef enum {S_OFF, S_START, S_DELAY, S_CONV, S_WRAP, S_SETTLE, S_FIN} acs_state_e;

    typedef logic signed [15:0] acs_sample_t;

    // converter setup register layout, msb first
    typedef struct packed {
        logic [2:0] avg_code;   // [16:14] averaging count code
        logic [2:0] ct_temp;    // [13:11] temperature time code
        logic [2:0] ct_bus;     // [10:8] bus time code
        logic [2:0] ct_shunt;   // [7:5] shunt time code
        logic [2:0] enables;    // [4:2] temp, bus, shunt
        acs_op_e op;            // [1:0] operating mode
    } acs_setup_s;

    // derived current and power pair
    typedef struct packed {
        logic signed [15:0] current;
        logic signed [23:0] power;
    } acs_calc_s;

endpackage : acs_pkg

// File: design/acs_math.sv
// background current and power computation, two register stages
`timescale 1ns/100ps
`include "acs_params.svh"
module acs_math
    import acs_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic go,             // bus sample landed, or shunt sample with bus disabled
    input wire acs_sample_t shunt,
    input wire acs_sample_t bus,
    input wire logic [15:0] cal,     // shunt scaling value
    output acs_calc_s calc,          // newest current and power
    output logic valid               // pulse two cycles after go
);

    logic signed [15:0] cur_reg;     // stage one: current
    logic signed [15:0] cur_next;
    logic signed [23:0] pwr_reg;     // stage two: power
    logic signed [23:0] pwr_next;
    logic [1:0] vld_reg;
    logic [1:0] vld_next;
    logic signed [32:0] cur_prod;
    logic signed [31:0] pwr_prod;

    // -----------------------------------------------------------------
    // arithmetic
    // -----------------------------------------------------------------
    // power uses the current of the stage before, with the latest bus
    always_comb
    begin
        cur_prod = shunt * $signed({1'b0, cal});
        pwr_prod = cur_reg * bus;
        cur_next = go ? 16'(cur_prod >>> `ACS_CUR_SHIFT) : cur_reg;
        pwr_next = pwr_reg;
        if (vld_reg[0])
            pwr_next = (cal == 16'h0) ? 24'sh0 : 24'(pwr_prod >>> 8);
        vld_next = {vld_reg[0], go};
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cur_reg <= 16'sh0;
            pwr_reg <= 24'sh0;
            vld_reg <= 2'h0;
        end
        else
        begin
            cur_reg <= cur_next;
            pwr_reg <= pwr_next;
            vld_reg <= vld_next;
        end
    end

    assign calc = '{current: cur_reg, power: pwr_reg};
    assign valid = vld_reg[1];

endmodule : acs_math

// File: design/acs_sequencer.sv
// conversion sequencer top: apb registers, input stepping, averaging
`timescale 1ns/100ps
`include "acs_params.svh"
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int US_CYC = `ACS_US_CYC,               // cycles per microsecond
    parameter int DLY_STEP_CYC = `ACS_DLY_STEP_CYC     // cycles per delay step
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire acs_sample_t sample_in,   // filtered result of the front end
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [1:0] mux_sel,          // 0 shunt, 1 bus, 2 temperature
    output logic converting              // a conversion period is running
);

    // -----------------------------------------------------------------
    // encodings
    // -----------------------------------------------------------------
    // conversion time per code, microseconds
    function automatic int ct_us(input logic [2:0] code);
        case (code)
            3'h0: ct_us = `ACS_CT_MIN_US;
            3'h1: ct_us = 100;
            3'h2: ct_us = 200;
            3'h3: ct_us = 400;
            3'h4: ct_us = 800;
            3'h5: ct_us = 1052;
            3'h6: ct_us = 2060;
            default: ct_us = `ACS_CT_MAX_US;
        endcase
    endfunction : ct_us

    // averaging count as a power of two: 1,2,4,8,16,64,256,1024
    function automatic logic [3:0] avg_shift(input logic [2:0] code);
        case (code)
            3'h5: avg_shift = 4'd6;
            3'h6: avg_shift = 4'd8;
            3'h7: avg_shift = 4'd10;
            default: avg_shift = {1'b0, code};
        endcase
    endfunction : avg_shift

    // lowest enabled input at or above start; bit 2 flags none found
    function automatic logic [2:0] next_ch(input logic [2:0] en, input logic [1:0] start);
        next_ch = 3'h4;
        for (int i = 2; i >= 0; i--)
            if (en[i] && (i >= start))
                next_ch = 3'(i);
    endfunction : next_ch

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    acs_setup_s setup_reg, setup_next;      // converter setup
    logic [7:0] dly_reg, dly_next;          // start delay field
    logic [15:0] cal_reg, cal_next;         // shunt scaling
    logic done_flag_reg, done_flag_next;    // conversion done flag
    acs_sample_t res_reg [3];               // shunt, bus, temp results
    acs_sample_t res_next [3];
    logic signed [31:0] acc_reg [3];        // input accumulators
    logic signed [31:0] acc_next [3];
    logic signed [15:0] cur_res_reg, cur_res_next;
    logic signed [23:0] pwr_res_reg, pwr_res_next;
    logic signed [31:0] cur_acc_reg, cur_acc_next;
    logic signed [39:0] pwr_acc_reg, pwr_acc_next;
    acs_sample_t shunt_reg, shunt_next;     // latest raw shunt sample
    acs_sample_t bus_reg, bus_next;         // latest raw bus sample
    acs_state_e state_reg, state_next;
    logic [1:0] ch_reg, ch_next;            // input being converted
    logic [10:0] pass_reg, pass_next;       // completed passes
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic conv_reg, conv_next;

    logic tmr_load;                         // timer start
    logic [31:0] tmr_count;
    logic tmr_done;
    logic math_go;
    acs_calc_s math_calc;
    logic math_valid;

    // bus phases
    logic acc_phase;                        // access phase, answer pending
    logic xfer;                             // transfer completes this edge
    logic mapped;
    logic setup_wr;
    logic [3:0] shift;
    logic [2:0] nx;

    acs_timer u_timer (
        .mclk(mclk),
        .reset(reset),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    acs_math u_math (
        .mclk(mclk),
        .reset(reset),
        .go(math_go),
        .shunt(shunt_next),
        .bus(bus_next),
        .cal(cal_reg),
        .calc(math_calc),
        .valid(math_valid)
    );

    // -----------------------------------------------------------------
    // next-state logic
    // -----------------------------------------------------------------
    always_comb
    begin
        acc_phase = psel && penable && !pready_reg;
        xfer = psel && penable && pready_reg;
        mapped = (paddr <= `ACS_ADDR_RES_PWR) && (paddr[1:0] == 2'h0);
        setup_wr = xfer && pwrite && (paddr == `ACS_ADDR_SETUP);
        shift = avg_shift(setup_reg.avg_code);
        // defaults: hold everything
        setup_next = setup_reg;
        dly_next = dly_reg;
        cal_next = cal_reg;
        res_next = res_reg;
        acc_next = acc_reg;
        cur_res_next = cur_res_reg;
        pwr_res_next = pwr_res_reg;
        cur_acc_next = cur_acc_reg;
        pwr_acc_next = pwr_acc_reg;
        shunt_next = shunt_reg;
        bus_next = bus_reg;
        state_next = state_reg;
        ch_next = ch_reg;
        pass_next = pass_reg;
        conv_next = conv_reg;
        tmr_load = 1'b0;
        tmr_count = 32'h1;
        math_go = 1'b0;
        nx = 3'h4;
        // one wait state, then answer
        pready_next = acc_phase;
        pslverr_next = acc_phase && !mapped;
        prdata_next = 32'h0;
        if (acc_phase && !pwrite)
        begin
            case (paddr)
                `ACS_ADDR_SETUP: prdata_next = 32'(setup_reg);
                `ACS_ADDR_CONFIG: prdata_next = 32'(dly_reg);
                `ACS_ADDR_DIAG: prdata_next = 32'(done_flag_reg);
                `ACS_ADDR_CAL: prdata_next = 32'(cal_reg);
                `ACS_ADDR_RES_SHUNT: prdata_next = 32'($unsigned(res_reg[0]));
                `ACS_ADDR_RES_BUS: prdata_next = 32'($unsigned(res_reg[1]));
                `ACS_ADDR_RES_TEMP: prdata_next = 32'($unsigned(res_reg[2]));
                `ACS_ADDR_RES_CUR: prdata_next = 32'($unsigned(cur_res_reg));
                `ACS_ADDR_RES_PWR: prdata_next = 32'($unsigned(pwr_res_reg));
                default: prdata_next = 32'h0;
            endcase
        end
        // register writes, allowed in every state
        if (xfer && pwrite)
        begin
            case (paddr)
                `ACS_ADDR_SETUP: setup_next = acs_setup_s'(pwdata[`ACS_SETUP_W-1:0]);
                `ACS_ADDR_CONFIG: dly_next = pwdata[`ACS_DLY_W-1:0];
                `ACS_ADDR_CAL: cal_next = pwdata[15:0];
                default: ;
            endcase
        end
        // background current and power accumulation
        if (math_valid)
        begin
            cur_acc_next = cur_acc_reg + 32'(math_calc.current);
            pwr_acc_next = pwr_acc_reg + 40'(math_calc.power);
        end
        // sequencer
        case (state_reg)
            S_OFF:
                conv_next = 1'b0;
            S_START:
            begin
                if (dly_reg == 8'h0)
                    state_next = S_WRAP;
                else
                begin
                    tmr_load = 1'b1;
                    tmr_count = 32'(dly_reg) * 32'(DLY_STEP_CYC);
                    state_next = S_DELAY;
                end
            end
            S_DELAY:
                if (tmr_done)
                    state_next = S_WRAP;
            S_CONV:
            begin
                if (tmr_done && !setup_wr)
                begin
                    // sample taken after the filter settled over the period
                    if (shift == 4'h0)
                        res_next[ch_reg] = sample_in;
                    else
                        acc_next[ch_reg] = acc_reg[ch_reg] + 32'(sample_in);
                    if (ch_reg == 2'h0)
                        shunt_next = sample_in;
                    if (ch_reg == 2'h1)
                        bus_next = sample_in;
                    math_go = (ch_reg == 2'h1) || (ch_reg == 2'h0 && !setup_reg.enables[1]);
                    nx = (ch_reg == 2'h2) ? 3'h4 : next_ch(setup_reg.enables, ch_reg + 2'h1);
                    if (!nx[2])
                    begin
                        ch_next = nx[1:0];
                        tmr_load = 1'b1;
                        tmr_count = 32'(ct_us(nx[1:0] == 2'h0 ? setup_reg.ct_shunt :
                            nx[1:0] == 2'h1 ? setup_reg.ct_bus : setup_reg.ct_temp) * US_CYC);
                    end
                    else
                    begin
                        state_next = S_SETTLE;
                        conv_next = 1'b0;
                    end
                end
            end
            S_SETTLE:
                state_next = S_FIN; // let the power stage finish
            S_FIN:
            begin
                pass_next = pass_reg + 11'h1;
                state_next = S_WRAP;
                if ((pass_reg + 11'h1) == (11'h1 << shift))
                begin
                    for (int i = 0; i < 3; i++)
                    begin
                        if (setup_reg.enables[i] && shift != 4'h0)
                            res_next[i] = 16'(acc_reg[i] >>> shift);
                        acc_next[i] = 32'sh0;
                    end
                    // sums include a sample that lands in this cycle
                    cur_res_next = 16'(cur_acc_next >>> shift);
                    pwr_res_next = 24'(pwr_acc_next >>> shift);
                    cur_acc_next = 32'sh0;
                    pwr_acc_next = 40'sh0;
                    pass_next = 11'h0;
                    if (setup_reg.op == ACS_OP_TRIG)
                        state_next = S_OFF;
                end
            end
            default: // S_WRAP: begin a pass at the first enabled input
            begin
                nx = next_ch(setup_reg.enables, 2'h0);
                if (nx[2])
                    state_next = S_OFF;
                else
                begin
                    ch_next = nx[1:0];
                    tmr_load = 1'b1;
                    tmr_count = 32'(ct_us(nx[1:0] == 2'h0 ? setup_reg.ct_shunt :
                        nx[1:0] == 2'h1 ? setup_reg.ct_bus : setup_reg.ct_temp) * US_CYC);
                    state_next = S_CONV;
                    conv_next = 1'b1;
                end
            end
        endcase
        // a mode write overrides the sequence in any state
        if (setup_wr)
        begin
            acc_next = '{default: 32'sh0};
            cur_acc_next = 32'sh0;
            pwr_acc_next = 40'sh0;
            pass_next = 11'h0;
            conv_next = 1'b0;
            tmr_load = 1'b1;
            tmr_count = 32'h0;
            state_next = (setup_next.op == ACS_OP_OFF) ? S_OFF : S_START;
        end
        // done flag: set wins over a diag read clear; a setup write blocks the set
        done_flag_next = done_flag_reg;
        if ((setup_wr && setup_next.op != ACS_OP_OFF)
            || (acc_phase && !pwrite && paddr == `ACS_ADDR_DIAG))
            done_flag_next = 1'b0;
        if (state_reg == S_FIN && (pass_reg + 11'h1) == (11'h1 << shift) && !setup_wr)
            done_flag_next = 1'b1;
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            setup_reg <= acs_setup_s'(`ACS_SETUP_RST);
            dly_reg <= `ACS_DLY_RST;
            cal_reg <= `ACS_CAL_RST;
            done_flag_reg <= 1'b0;
            res_reg <= '{default: 16'sh0};
            acc_reg <= '{default: 32'sh0};
            cur_res_reg <= 16'sh0;
            pwr_res_reg <= 24'sh0;
            cur_acc_reg <= 32'sh0;
            pwr_acc_reg <= 40'sh0;
            shunt_reg <= 16'sh0;
            bus_reg <= 16'sh0;
            state_reg <= S_START;
            ch_reg <= 2'h0;
            pass_reg <= 11'h0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            conv_reg <= 1'b0;
        end
        else
        begin
            setup_reg <= setup_next;
            dly_reg <= dly_next;
            cal_reg <= cal_next;
            done_flag_reg <= done_flag_next;
            res_reg <= res_next;
            acc_reg <= acc_next;
            cur_res_reg <= cur_res_next;
            pwr_res_reg <= pwr_res_next;
            cur_acc_reg <= cur_acc_next;
            pwr_acc_reg <= pwr_acc_next;
            shunt_reg <= shunt_next;
            bus_reg <= bus_next;
            state_reg <= state_next;
            ch_reg <= ch_next;
            pass_reg <= pass_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            conv_reg <= conv_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign mux_sel = ch_reg;
    assign converting = conv_reg;

endmodule : acs_sequencer

// File: design/acs_timer.sv
// down counter timing delays and conversion periods
`timescale 1ns/100ps
module acs_timer
    import acs_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic load,         // start a new period
    input wire logic [31:0] count, // period length in cycles, zero stops the timer
    output logic done               // one cycle pulse at period end
);

    logic [31:0] cnt_reg;  // cycles left
    logic [31:0] cnt_next;

    // -----------------------------------------------------------------
    // counting
    // -----------------------------------------------------------------
    // a load restarts the count, so an aborted period never ends late
    always_comb
    begin
        if (load)
            cnt_next = count;
        else if (cnt_reg != 32'h0)
            cnt_next = cnt_reg - 32'h1;
        else
            cnt_next = 32'h0;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            cnt_reg <= 32'h0;
        else
            cnt_reg <= cnt_next;
    end

    // no load term here: the sequencer derives load from done
    assign done = (cnt_reg == 32'h1);

endmodule : acs_timer

// File: sim/acs_front_model.sv
// front-end model: settled sample for the selected input
`timescale 1ns/100ps
module acs_front_model
    import acs_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [1:0] mux_sel,
    input wire logic converting,
    input wire logic [15:0] offset,   // added to every input's value
    output acs_sample_t sample_in
);
    acs_sample_t last_reg; // last value shown
    acs_sample_t level;    // 0x100 shunt, 0x200 bus, 0x300 temp
    // value while converting, a changing pattern while idle
    always_comb
    begin
        level = acs_sample_t'({6'h0, mux_sel + 2'h1, 8'h00} + offset);
    end
    assign sample_in = converting ? level : ~last_reg;
    // remember what was shown
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            last_reg <= '0;
        else
            last_reg <= sample_in;
    end
endmodule : acs_front_model

// File: sim/acs_seq_monitor.sv
// port checker for the conversion sequencer
`timescale 1ns/100ps
module acs_seq_monitor
    import acs_pkg::*;
#(
    parameter int US_CYC = 100,          // cycles per microsecond
    parameter int DLY_STEP_CYC = 200000  // cycles per delay step
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire acs_sample_t sample_in,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] mux_sel,
    input wire logic converting
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // bus handshake and register reads
    // ----------------------------------------
    sequence s_access;
        (psel && !penable) ##1 (psel && penable);
    endsequence
    chk_one_wait: assert property (s_access |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_pair: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_err_map: assert property (pready && (paddr > 8'h20 || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access not refused");
    chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read data not zero");
    chk_diag_bits: assert property (pready && !pwrite && paddr == 8'h08 |-> prdata[31:1] == 31'h0)
        else $error("diag upper bits not zero");
    chk_setup_bits: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[31:17] == 15'h0)
        else $error("setup upper bits not zero");
    // ----------------------------------------
    // sequencer start and input select
    // ----------------------------------------
    chk_mux_range: assert property (converting |-> mux_sel != 2'h3)
        else $error("no such input selected");
    chk_off_stops: assert property (pready && pwrite && paddr == 8'h00
        && pwdata[1:0] == 2'h0 |=> !converting)
        else $error("shutdown write left conversion running");
    chk_reset_start: assert property ($fell(reset) |-> !converting ##1 !converting ##1 converting)
        else $error("first conversion not started undelayed");
endmodule : acs_seq_monitor

bind acs_sequencer acs_seq_monitor #(.US_CYC(US_CYC), .DLY_STEP_CYC(DLY_STEP_CYC)) u_acs_seq_monitor (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .sample_in(sample_in), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mux_sel(mux_sel), .converting(converting));

// File: sim/tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`include "acs_params.svh"
module tb
    import acs_pkg::*;
;
    logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, converting, er;
    logic [1:0] mux_sel;
    logic [15:0] offset = 16'h0;
    acs_sample_t sample_in;
    int fails = 0, tests_run = 0, wn = 0;
    always #5 mclk = ~mclk;
    acs_sequencer #(.US_CYC(1), .DLY_STEP_CYC(4)) u_acs_sequencer (.mclk(mclk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .sample_in(sample_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mux_sel(mux_sel), .converting(converting));
    acs_front_model u_acs_front_model (.mclk(mclk), .reset(reset), .mux_sel(mux_sel),
        .converting(converting), .offset(offset), .sample_in(sample_in));
    // ----------------------------------------
    // verdict, compare and bus tasks
    // ----------------------------------------
    task results;
        if (fails == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // one apb transfer, held until pready is seen at a rising edge
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 20)
        begin
            fails++;
            results;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : xfer
    task rcheck(input string name, input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        check(name, exp, rd);
    endtask : rcheck
    // poll the done flag, bounded
    task wait_done;
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[0] !== 1'b1 && n < 400)
        begin
            xfer(`ACS_ADDR_DIAG, 1'b0, 32'h0);
            n++;
        end
        if (n == 400)
        begin
            fails++;
            results;
        end
    endtask : wait_done
    task wait_conv(input logic v);
        wn = 0;
        while (converting !== v && wn < 3000)
        begin
            @(negedge mclk);
            wn++;
        end
        if (wn == 3000)
        begin
            fails++;
            results;
        end
    endtask : wait_conv
    function automatic logic [31:0] mk(acs_op_e op, logic [2:0] en, logic [2:0] avg);
        acs_setup_s s;
        s = '0;
        s.op = op;
        s.enables = en;
        s.avg_code = avg;
        return {15'h0, s};
    endfunction : mk
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        rcheck("setup", `ACS_ADDR_SETUP, {15'h0, `ACS_SETUP_RST});
        rcheck("delay", `ACS_ADDR_CONFIG, 32'h0);
        xfer(8'h24, 1'b0, 32'h0);
        check("refused", 32'h1, {31'h0, er});
        xfer(`ACS_ADDR_CAL, 1'b1, 32'h800);
        rcheck("cal", `ACS_ADDR_CAL, 32'h800);
        // single shot, shunt and bus only
        xfer(`ACS_ADDR_SETUP, 1'b1, mk(ACS_OP_TRIG, 3'b011, 3'h0));
        wait_done;
        rcheck("shunt", `ACS_ADDR_RES_SHUNT, 32'h100);
        rcheck("bus", `ACS_ADDR_RES_BUS, 32'h200);
        rcheck("temp", `ACS_ADDR_RES_TEMP, 32'h0);
        rcheck("current", `ACS_ADDR_RES_CUR, 32'h100);
        rcheck("power", `ACS_ADDR_RES_PWR, 32'h200);
        rcheck("flag", `ACS_ADDR_DIAG, 32'h0);
        offset <= 16'h2;
        repeat (100) @(posedge mclk);
        @(negedge mclk);
        check("idle", 32'h0, {31'h0, converting});
        // two-sample average, results held until the end
        xfer(`ACS_ADDR_SETUP, 1'b1, mk(ACS_OP_TRIG, 3'b011, 3'h1));
        wait_conv(1'b1);
        wait_conv(1'b0);
        rcheck("held", `ACS_ADDR_RES_SHUNT, 32'h100);
        wait_done;
        rcheck("avg shunt", `ACS_ADDR_RES_SHUNT, 32'h102);
        rcheck("avg bus", `ACS_ADDR_RES_BUS, 32'h202);
        rcheck("avg current", `ACS_ADDR_RES_CUR, 32'h102);
        rcheck("avg power", `ACS_ADDR_RES_PWR, 32'h206);
        // continuous with zero scaling, then abort to shutdown
        xfer(`ACS_ADDR_CAL, 1'b1, 32'h0);
        xfer(`ACS_ADDR_SETUP, 1'b1, mk(ACS_OP_CONT, 3'b011, 3'h0));
        wait_done;
        rcheck("zero power", `ACS_ADDR_RES_PWR, 32'h0);
        wait_done;
        xfer(`ACS_ADDR_SETUP, 1'b1, mk(ACS_OP_OFF, 3'b011, 3'h0));
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        check("stopped", 32'h0, {31'h0, converting});
        // start delay of two steps
        xfer(`ACS_ADDR_CONFIG, 1'b1, 32'h2);
        rcheck("delay", `ACS_ADDR_CONFIG, 32'h2);
        xfer(`ACS_ADDR_SETUP, 1'b1, mk(ACS_OP_TRIG, 3'b001, 3'h0) | 32'h20);
        repeat (7) @(posedge mclk);
        @(negedge mclk);
        check("delayed", 32'h0, {31'h0, converting});
        wait_conv(1'b1);
        wait_conv(1'b0);
        check("period", 32'd100, 32'(wn));
        wait_done;
        rcheck("late shunt", `ACS_ADDR_RES_SHUNT, 32'h102);
        results;
    end
endmodule : tb
